//--- hdl/serial_shifter.sv
// Input shift register clocked by the serial clock
`timescale 1ns/10ps
`default_nettype none
module serial_shifter (
    input wire logic serial_clk,
    input wire logic rstn,
    input wire logic serial_data,
    shift_word_if.src sh
);
    // ------------------------------------------------------------------------
    // Shifting
    // ------------------------------------------------------------------------
    // Most significant bit first; keeps shifting during power-down
    always_ff @(posedge serial_clk or negedge rstn) begin
        if (!rstn) begin
            sh.word <= 24'h000000;
        end else begin
            sh.word <= {sh.word[22:0], serial_data};
        end
    end
endmodule // serial_shifter
`default_nettype wire

//--- hdl/shift_word_if.sv
// Carrier for the shifted word between the serial-clock shifter and the latch logic
`timescale 1ns/10ps
`default_nettype none
interface shift_word_if;
    synth_latch_pkg::latch_word_t word;
    modport src (output word);
    modport dst (input word);
endinterface : shift_word_if
`default_nettype wire

//--- hdl/synth_latch_pkg.sv
// Types shared by the synthesizer latch bank
package synth_latch_pkg;
    typedef enum logic [1:0] {PWR_RUN, PWR_SYNC_WAIT, PWR_DOWN} power_state_e;
    typedef enum logic [1:0] {SEQ_NONE, SEQ_REF, SEQ_CTL, SEQ_READY} sequence_state_e;
    typedef logic [23:0] latch_word_t;
endpackage

//--- hdl/synth_latch_power_control.sv
// Latch bank and power-down sequencing of the synthesizer
`timescale 1ns/10ps
`default_nettype none
`include "synth_latch_regs.svh"
module synth_latch_power_control #(
    parameter int SWALLOW_W = 5,
    parameter int MAIN_W = 13,
    parameter int SYNC_PD_EDGES = `SYNC_PD_EDGES,
    parameter int SETTLE_CYCLES = `SETTLE_LONG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic ref_div_out,
    input wire logic loop_locked,
    output logic power_down_r,
    output logic counters_load_r,
    output logic pump_hiz_r,
    output logic [2:0] pump_current_r,
    output logic pump_gain_r,
    output logic detector_polarity_r,
    output logic lock_detect_clear_r,
    output logic ref_buffer_en_r,
    output logic rf_out_en_r,
    output logic [1:0] prescaler_sel_r,
    output logic [1:0] out_level_r,
    output logic [1:0] core_bias_r,
    output logic [2:0] monitor_select_r,
    output logic [SWALLOW_W-1:0] swallow_count_r,
    output logic [MAIN_W-1:0] main_count_r,
    output logic [17:0] feedback_total_r,
    output logic out_halve_r,
    output logic halve_to_prescaler_r,
    output logic [21:0] ref_divider_r,
    output logic settle_done_r,
    output logic sequence_fault_r,
    output logic divider_changed_in_pd_r
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Field slices below are fixed by the word layout
    if (SWALLOW_W != 5 || MAIN_W != 13) begin : g_bad_width
        $error("synth_latch_power_control: field widths must be 5 and 13");
    end
    if (SYNC_PD_EDGES < 1 || SYNC_PD_EDGES > 15) begin : g_bad_edges
        $error("synth_latch_power_control: SYNC_PD_EDGES must be 1 to 15");
    end
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("synth_latch_power_control: SETTLE_CYCLES must be positive");
    end

    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [3:0] PD_EDGE_LAST = 4'(SYNC_PD_EDGES - 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

    // ------------------------------------------------------------------------
    // Serial-clock domain
    // ------------------------------------------------------------------------
    shift_word_if sh ();

    serial_shifter u_shifter (
        .serial_clk (serial_clk),
        .rstn (rstn),
        .serial_data (serial_data),
        .sh (sh.src)
    );

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic strobe_s1, strobe_s2, strobe_s3;
    logic ce_s1, ce_s2;
    logic ref_s1, ref_s2, ref_s3;
    logic lock_s1, lock_s2;

    // Two flops per pin; third stage only for edge detection
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_s3 <= 1'b0;
            ce_s1 <= 1'b0;
            ce_s2 <= 1'b0;
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            strobe_s1 <= load_strobe;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
            ce_s1 <= chip_enable;
            ce_s2 <= ce_s1;
            ref_s1 <= ref_div_out;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            lock_s1 <= loop_locked;
            lock_s2 <= lock_s1;
        end
    end

    logic strobe_rise;
    logic ref_rise;
    assign strobe_rise = strobe_s2 & ~strobe_s3;
    assign ref_rise = ref_s2 & ~ref_s3;

    // ------------------------------------------------------------------------
    // Latch transfer
    // ------------------------------------------------------------------------
    // The shifted word is quiet while the strobe is high, so it is safe to
    // sample here once the strobe edge has been synchronised
    logic [1:0] sel;
    logic load_ctl, load_ref, load_div;
    assign sel = sh.word[`SEL_LSB +: 2];
    assign load_ctl = strobe_rise && (sel == `SEL_CONTROL);
    assign load_ref = strobe_rise && (sel == `SEL_REFDIV);
    assign load_div = strobe_rise && (sel == `SEL_DIVIDER);

    synth_latch_pkg::latch_word_t ctl_r, div_r, ref_r;

    // Select code 11 is ignored; select bits read back as zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= `CTL_RESET;
            div_r <= `DIV_RESET;
            ref_r <= `REF_RESET;
        end else begin
            if (load_ctl) begin
                ctl_r <= {sh.word[23:2], 2'b00};
            end
            if (load_div) begin
                div_r <= {sh.word[23:2], 2'b00};
            end
            if (load_ref) begin
                ref_r <= {sh.word[23:2], 2'b00};
            end
        end
    end

    // Shared gain bit follows whichever of the control and divider latches was written last
    logic gain_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gain_r <= 1'b0;
        end else if (load_ctl) begin
            gain_r <= sh.word[`CTL_GAIN];
        end else if (load_div) begin
            gain_r <= sh.word[`DIV_GAIN];
        end
    end

    // ------------------------------------------------------------------------
    // Power-down sequencing
    // ------------------------------------------------------------------------
    synth_latch_pkg::power_state_e pwr_r;
    logic [3:0] edge_cnt_r;
    logic pd_bit0, pd_bit1;
    assign pd_bit0 = sh.word[`CTL_PD_BIT0];
    assign pd_bit1 = sh.word[`CTL_PD_BIT1];

    // Synchronous mode waits for reference edges so the pump is not cut mid-pulse
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pwr_r <= synth_latch_pkg::PWR_RUN;
            edge_cnt_r <= 4'h0;
        end else if (load_ctl) begin
            edge_cnt_r <= 4'h0;
            if (pd_bit0 && !pd_bit1) begin
                pwr_r <= synth_latch_pkg::PWR_DOWN;
            end else if (pd_bit0 && pd_bit1) begin
                pwr_r <= synth_latch_pkg::PWR_SYNC_WAIT;
            end else begin
                pwr_r <= synth_latch_pkg::PWR_RUN;
            end
        end else begin
            case (pwr_r)
                synth_latch_pkg::PWR_SYNC_WAIT: begin
                    if (ref_rise) begin
                        if (edge_cnt_r == PD_EDGE_LAST) begin
                            pwr_r <= synth_latch_pkg::PWR_DOWN;
                        end else begin
                            edge_cnt_r <= edge_cnt_r + 4'h1;
                        end
                    end
                end
                synth_latch_pkg::PWR_RUN: begin
                    edge_cnt_r <= 4'h0;
                end
                synth_latch_pkg::PWR_DOWN: begin
                    edge_cnt_r <= 4'h0;
                end
                default: begin
                    pwr_r <= synth_latch_pkg::PWR_RUN;
                end
            endcase
        end
    end

    // Chip enable overrides the programmed state
    logic pd_now;
    assign pd_now = (pwr_r == synth_latch_pkg::PWR_DOWN) || !ce_s2;

    // ------------------------------------------------------------------------
    // Analog-side controls
    // ------------------------------------------------------------------------
    logic [2:0] cur_one, cur_two;
    assign cur_one = ctl_r[`CTL_CUR_ONE_LSB +: 3];
    assign cur_two = ctl_r[`CTL_CUR_TWO_LSB +: 3];

    // Power-down forces loads, high impedance and disables
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            power_down_r <= 1'b1;
            counters_load_r <= 1'b1;
            pump_hiz_r <= 1'b1;
            lock_detect_clear_r <= 1'b1;
            ref_buffer_en_r <= 1'b0;
            rf_out_en_r <= 1'b0;
        end else begin
            power_down_r <= pd_now;
            counters_load_r <= pd_now || ctl_r[`CTL_CNT_RESET];
            pump_hiz_r <= pd_now || ctl_r[`CTL_PUMP_HIZ];
            lock_detect_clear_r <= pd_now;
            ref_buffer_en_r <= !pd_now;
            rf_out_en_r <= !pd_now && (!ctl_r[`CTL_MUTE] || lock_s2);
        end
    end

    // Current selection and plain control fields
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pump_current_r <= 3'h0;
            pump_gain_r <= 1'b0;
            detector_polarity_r <= 1'b0;
            prescaler_sel_r <= 2'h0;
            out_level_r <= 2'h0;
            core_bias_r <= 2'h0;
            monitor_select_r <= 3'h0;
        end else begin
            pump_current_r <= gain_r ? cur_two : cur_one;
            pump_gain_r <= gain_r;
            detector_polarity_r <= ctl_r[`CTL_POLARITY];
            prescaler_sel_r <= ctl_r[`CTL_PRESC_LSB +: 2];
            out_level_r <= ctl_r[`CTL_LEVEL_LSB +: 2];
            core_bias_r <= ctl_r[`CTL_CORE_BIAS_LSB +: 2];
            monitor_select_r <= ctl_r[`CTL_MONITOR_LSB +: 3];
        end
    end

    // ------------------------------------------------------------------------
    // Feedback divider
    // ------------------------------------------------------------------------
    logic [SWALLOW_W-1:0] swallow;
    logic [MAIN_W-1:0] main_cnt;
    logic [17:0] presc_mod;
    logic [17:0] total_nxt;
    assign swallow = div_r[`DIV_SWALLOW_LSB +: SWALLOW_W];
    assign main_cnt = div_r[`DIV_MAIN_LSB +: MAIN_W];

    // Product fits in 18 bits: 16 * 8191 + 31
    always_comb begin
        presc_mod = (ctl_r[`CTL_PRESC_LSB +: 2] == 2'h0) ? `PRESC_MOD_LOW : `PRESC_MOD_HIGH;
        total_nxt = 18'(presc_mod * {5'h00, main_cnt}) + {13'h0000, swallow};
    end

    // Divider fields and output halving options
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            swallow_count_r <= '0;
            main_count_r <= '0;
            feedback_total_r <= 18'h00000;
            out_halve_r <= 1'b0;
            halve_to_prescaler_r <= 1'b0;
            ref_divider_r <= 22'h000000;
        end else begin
            swallow_count_r <= swallow;
            main_count_r <= main_cnt;
            feedback_total_r <= total_nxt;
            out_halve_r <= div_r[`DIV_HALVE];
            halve_to_prescaler_r <= div_r[`DIV_HALVE_SEL];
            ref_divider_r <= ref_r[23:2];
        end
    end

    // ------------------------------------------------------------------------
    // Programming order watch
    // ------------------------------------------------------------------------
    // Reports host slips; it never blocks a write, since latching must always work
    synth_latch_pkg::sequence_state_e seq_r;
    logic [SETTLE_W-1:0] settle_cnt_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seq_r <= synth_latch_pkg::SEQ_NONE;
            sequence_fault_r <= 1'b0;
        end else if (load_ref) begin
            seq_r <= synth_latch_pkg::SEQ_REF;
            sequence_fault_r <= 1'b0;
        end else begin
            case (seq_r)
                synth_latch_pkg::SEQ_NONE: begin
                    if (load_ctl || load_div) begin
                        sequence_fault_r <= 1'b1;
                    end
                end
                synth_latch_pkg::SEQ_REF: begin
                    if (load_ctl) begin
                        seq_r <= synth_latch_pkg::SEQ_CTL;
                    end else if (load_div) begin
                        sequence_fault_r <= 1'b1;
                    end
                end
                synth_latch_pkg::SEQ_CTL: begin
                    if (load_div) begin
                        seq_r <= synth_latch_pkg::SEQ_READY;
                        if (!settle_done_r) begin
                            sequence_fault_r <= 1'b1;
                        end
                    end
                end
                synth_latch_pkg::SEQ_READY: begin
                    if (load_div && divider_changed_in_pd_r) begin
                        sequence_fault_r <= 1'b1;
                    end
                end
                default: begin
                    seq_r <= synth_latch_pkg::SEQ_NONE;
                end
            endcase
        end
    end

    // Settling timer restarts on each control latch write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_cnt_r <= '0;
            settle_done_r <= 1'b0;
        end else if (load_ctl) begin
            settle_cnt_r <= '0;
            settle_done_r <= 1'b0;
        end else if (!settle_done_r) begin
            if (settle_cnt_r == SETTLE_LAST) begin
                settle_done_r <= 1'b1;
            end else begin
                settle_cnt_r <= settle_cnt_r + 1'b1;
            end
        end
    end

    // Divider touched while powered down; cleared by a fresh reference write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            divider_changed_in_pd_r <= 1'b0;
        end else if (load_div && pd_now) begin
            divider_changed_in_pd_r <= 1'b1;
        end else if (load_ref) begin
            divider_changed_in_pd_r <= 1'b0;
        end
    end

endmodule // synth_latch_power_control
`default_nettype wire

//--- hdl/synth_latch_regs.svh
// Field positions, select codes, reset values and timing figures of the synthesizer latch bank
`ifndef SYNTH_LATCH_REGS_SVH
`define SYNTH_LATCH_REGS_SVH

// ----------------------------------------------------------------------------
// Serial word and latch select
// ----------------------------------------------------------------------------
`define WORD_BITS 24
`define SEL_LSB 0
`define SEL_CONTROL 2'h0
`define SEL_REFDIV 2'h1
`define SEL_DIVIDER 2'h2

// ----------------------------------------------------------------------------
// Control latch field positions
// ----------------------------------------------------------------------------
`define CTL_CORE_BIAS_LSB 2
`define CTL_CNT_RESET 4
`define CTL_MONITOR_LSB 5
`define CTL_POLARITY 8
`define CTL_PUMP_HIZ 9
`define CTL_GAIN 10
`define CTL_MUTE 11
`define CTL_LEVEL_LSB 12
`define CTL_CUR_ONE_LSB 14
`define CTL_CUR_TWO_LSB 17
`define CTL_PD_BIT0 20
`define CTL_PD_BIT1 21
`define CTL_PRESC_LSB 22

// ----------------------------------------------------------------------------
// Divider latch field positions
// ----------------------------------------------------------------------------
`define DIV_SWALLOW_LSB 2
`define DIV_RESERVED 7
`define DIV_MAIN_LSB 8
`define DIV_GAIN 21
`define DIV_HALVE 22
`define DIV_HALVE_SEL 23

// ----------------------------------------------------------------------------
// Reset values and prescaler moduli
// ----------------------------------------------------------------------------
`define CTL_RESET 24'h000000
`define DIV_RESET 24'h000300
`define REF_RESET 24'h000004
`define PRESC_MOD_LOW 18'h00008
`define PRESC_MOD_HIGH 18'h00010

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_MHZ 20
`define SETTLE_LONG_US 10000
`define SETTLE_SHORT_US 600
`define SETTLE_LONG_CYCLES (`SETTLE_LONG_US * `CLK_FREQ_MHZ)
`define SYNC_PD_EDGES 2

`endif

//--- verification/serial_host_model.sv
// Host model writing 24-bit words over the three-wire serial link
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
    input wire logic clk_sys,
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    // Link clock parked low between frames
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // One frame, then strobe; quiet gaps keep the strobe sync happy
    task automatic write_word(input logic [23:0] w);
        logic [23:0] v;
        v = w;
        if (v[1:0] == 2'h2) v[7] = 1'b0; // Reserved divider bit kept clear
        #7;
        for (int i = 23; i >= 0; i--) begin
            serial_data = v[i]; // MSB first, taken on rising link clock
            #16 serial_clk = 1'b1;
            #16 serial_clk = 1'b0;
        end
        serial_data = ~v[0]; // Stale data must not look valid
        @(posedge clk_sys);
        #2 load_strobe = 1'b1; // Rise transfers the word
        repeat (4) @(posedge clk_sys);
        #2 load_strobe = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
endmodule // serial_host_model
`default_nettype wire

//--- verification/synth_latch_power_control_monitor.sv
// Concurrent checks on the latch bank and power sequencing ports
`timescale 1ns/10ps
`default_nettype none
`include "synth_latch_regs.svh"
module synth_latch_power_control_monitor #(
    parameter int SWALLOW_W = 5,
    parameter int MAIN_W = 13,
    parameter int SYNC_PD_EDGES = 2,
    parameter int SETTLE_CYCLES = 50
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic power_down_r,
    input wire logic counters_load_r,
    input wire logic pump_hiz_r,
    input wire logic [2:0] pump_current_r,
    input wire logic lock_detect_clear_r,
    input wire logic ref_buffer_en_r,
    input wire logic rf_out_en_r,
    input wire logic [1:0] prescaler_sel_r,
    input wire logic [SWALLOW_W-1:0] swallow_count_r,
    input wire logic [MAIN_W-1:0] main_count_r,
    input wire logic [17:0] feedback_total_r,
    input wire logic [21:0] ref_divider_r,
    input wire logic sequence_fault_r,
    input wire logic divider_changed_in_pd_r
);
    logic strobe_d_r;
    logic [7:0] strobe_age_r;
    logic [3:0] ce_age_r;
    // Ages since strobe rise and enable rise; saturate so old events fade out
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strobe_d_r <= 1'b0;
            strobe_age_r <= 8'h02;
            ce_age_r <= 4'hF;
        end else begin
            strobe_d_r <= load_strobe;
            if (load_strobe && !strobe_d_r) strobe_age_r <= 8'h00;
            else if (strobe_age_r != 8'hFF) strobe_age_r <= strobe_age_r + 8'h01;
            if (!chip_enable) ce_age_r <= 4'h0;
            else if (ce_age_r != 4'hF) ce_age_r <= ce_age_r + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_ce_held_low;
        !chip_enable [*5];
    endsequence
    sequence s_fields_steady;
        $stable(prescaler_sel_r) && $stable(main_count_r) && $stable(swallow_count_r);
    endsequence
    // Side effects only judged once power-down has stood a cycle
    sequence s_down_settled;
        power_down_r && $past(power_down_r);
    endsequence
    a_ce_low_down: assert property (s_ce_held_low |-> power_down_r) else $error("enable low not disabling");
    a_pd_pump_hold: assert property (s_down_settled |-> pump_hiz_r && counters_load_r)
        else $error("pump or counters active in power-down");
    a_pd_outputs_off: assert property (s_down_settled |-> lock_detect_clear_r && !ref_buffer_en_r && !rf_out_en_r)
        else $error("outputs live in power-down");
    a_total_division: assert property (s_fields_steady [*2] |-> feedback_total_r ==
        (prescaler_sel_r == 2'h0 ? `PRESC_MOD_LOW : `PRESC_MOD_HIGH) * 18'(main_count_r) + 18'(swallow_count_r))
        else $error("feedback total mismatch");
    a_latch_hold: assert property (!$stable({pump_current_r, prescaler_sel_r, swallow_count_r, main_count_r,
        ref_divider_r}) |-> strobe_age_r <= 8'd10) else $error("latch changed without strobe");
    a_flags_clear: assert property ($fell(sequence_fault_r) || $fell(divider_changed_in_pd_r) |-> strobe_age_r <= 8'd10)
        else $error("sequence flag cleared without load");
    a_pd_change_flag: assert property ($rose(divider_changed_in_pd_r) |-> $past(power_down_r) && strobe_age_r <= 8'd10)
        else $error("divider change flag without load in power-down");
    a_power_up_cause: assert property ($fell(power_down_r) |-> strobe_age_r <= 8'd10 || ce_age_r <= 4'd8)
        else $error("power-up without load or enable");
endmodule // synth_latch_power_control_monitor
`default_nettype wire

//--- verification/synth_latch_power_control_tb_top.sv
// Self-checking bench for the latch bank and power sequencing
`timescale 1ns/10ps
`default_nettype none
`include "synth_latch_regs.svh"
module synth_latch_power_control_tb_top;
    localparam int SETTLE = 50;
    typedef struct packed {
        logic [23:0] word;
        logic [47:0] want;
    } row_s;
    logic clk_sys, rstn, chip_enable, ref_div_out, loop_locked, serial_clk, serial_data, load_strobe;
    logic power_down_r, counters_load_r, pump_hiz_r, pump_gain_r, detector_polarity_r, lock_detect_clear_r;
    logic ref_buffer_en_r, rf_out_en_r, out_halve_r, halve_to_prescaler_r, settle_done_r;
    logic sequence_fault_r, divider_changed_in_pd_r;
    logic [2:0] pump_current_r, monitor_select_r;
    logic [1:0] prescaler_sel_r, out_level_r, core_bias_r;
    logic [4:0] swallow_count_r;
    logic [12:0] main_count_r;
    logic [17:0] feedback_total_r;
    logic [21:0] ref_divider_r;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    row_s rows [6] = '{
        '{24'h0000D1, 48'h34}, // Reference word first
        '{24'h45616C, 48'hA8DB}, // Control, gain low
        '{24'hA00302, {6'h0, 3'h2, 5'h00, 13'h0003, 3'h3, 18'h00030}}, // Divider
        '{24'h055690, 48'h5624}, // Control, gain high
        '{24'hFFFFFF, 48'h5624}, // Select code 11 ignored
        '{24'h5FFF7E, {6'h0, 3'h5, 5'h1F, 13'h1FFF, 3'h4, 18'h10017}} // Divider max
    };
    serial_host_model host_inst (.clk_sys, .serial_clk, .serial_data, .load_strobe);
    synth_latch_power_control #(.SETTLE_CYCLES(SETTLE)) synth_latch_power_control_inst (
        .clk_sys, .rstn, .serial_clk, .serial_data, .load_strobe, .chip_enable, .ref_div_out, .loop_locked,
        .power_down_r, .counters_load_r, .pump_hiz_r, .pump_current_r, .pump_gain_r, .detector_polarity_r,
        .lock_detect_clear_r, .ref_buffer_en_r, .rf_out_en_r, .prescaler_sel_r, .out_level_r, .core_bias_r,
        .monitor_select_r, .swallow_count_r, .main_count_r, .feedback_total_r, .out_halve_r,
        .halve_to_prescaler_r, .ref_divider_r, .settle_done_r, .sequence_fault_r, .divider_changed_in_pd_r);
    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        n_compared++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Waits land just past the edge so register updates are visible
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [47:0] observe(input logic [1:0] sel);
        if (sel == `SEL_REFDIV) return {26'h0, ref_divider_r};
        if (sel == `SEL_DIVIDER) return {6'h0, pump_current_r, swallow_count_r, main_count_r, out_halve_r,
            halve_to_prescaler_r, pump_gain_r, feedback_total_r};
        return {32'h0, pump_current_r, pump_gain_r, detector_polarity_r, pump_hiz_r, counters_load_r,
            prescaler_sel_r, out_level_r, core_bias_r, monitor_select_r};
    endfunction
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Hang guard, well above the fewer than a thousand cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        rstn = 1'b0;
        chip_enable = 1'b1;
        ref_div_out = 1'b0;
        loop_locked = 1'b0;
        wait_cycles(16);
        check({power_down_r, ref_buffer_en_r, rf_out_en_r, lock_detect_clear_r}, 4'h9);
        #1 rstn = 1'b1;
        wait_cycles(8);
        check(power_down_r, 1'b0); // Enabled, power bits clear
        foreach (rows[i]) begin
            host_inst.write_word(rows[i].word);
            wait_cycles(SETTLE + 14); // Settle gap before any divider load
            check(observe(rows[i].word[1:0]), rows[i].want);
        end
        check({sequence_fault_r, settle_done_r}, 2'h1); // Order and wait kept
        host_inst.write_word(24'h100000);
        check({power_down_r, pump_hiz_r, counters_load_r, ref_buffer_en_r}, 4'hE); // Async down
        check(settle_done_r, 1'b0); // Fresh control load
        host_inst.write_word(24'hA00302);
        check({main_count_r, divider_changed_in_pd_r}, {13'h0003, 1'b1}); // Loads while down
        host_inst.write_word(24'h0000D1); // Sequence restarts after the change
        check(divider_changed_in_pd_r, 1'b0);
        host_inst.write_word(24'h000800);
        check({power_down_r, rf_out_en_r}, 2'h0); // Muted until lock
        @(posedge clk_sys) #2 loop_locked = ~loop_locked;
        wait_cycles(6);
        check(rf_out_en_r, 1'b1);
        host_inst.write_word(24'h300800);
        repeat (2) begin
            check(power_down_r, 1'b0); // Waits for reference edges
            @(posedge clk_sys) #2 ref_div_out = ~ref_div_out;
            repeat (8) @(posedge clk_sys);
            #2 ref_div_out = ~ref_div_out;
            wait_cycles(8);
        end
        check(power_down_r, 1'b1); // Down after second edge
        host_inst.write_word(24'h000000);
        host_inst.write_word(24'hA00302); // Deliberately too soon after control
        check({power_down_r, sequence_fault_r}, 2'h1);
        @(posedge clk_sys) #2 chip_enable = ~chip_enable;
        wait_cycles(5);
        check({power_down_r, ref_buffer_en_r}, 2'h2);
        @(posedge clk_sys) #2 chip_enable = ~chip_enable;
        wait_cycles(6);
        check(power_down_r, 1'b0);
        report_and_stop();
    end
endmodule // synth_latch_power_control_tb_top
bind synth_latch_power_control synth_latch_power_control_monitor #(.SWALLOW_W(SWALLOW_W), .MAIN_W(MAIN_W),
    .SYNC_PD_EDGES(SYNC_PD_EDGES), .SETTLE_CYCLES(SETTLE_CYCLES)) monitor_inst (
    .clk_sys, .rstn, .load_strobe, .chip_enable, .power_down_r, .counters_load_r, .pump_hiz_r, .pump_current_r,
    .lock_detect_clear_r, .ref_buffer_en_r, .rf_out_en_r, .prescaler_sel_r, .swallow_count_r, .main_count_r,
    .feedback_total_r, .ref_divider_r, .sequence_fault_r, .divider_changed_in_pd_r);
`default_nettype wire
